// ===== rtl/ssp_pkg.sv
// Shared constants and types for the sleep-state power controls
package ssp_pkg;
	// Encoding of the current system sleep state
	typedef enum logic [2:0] {
		SSP_S0 = 3'h0,
		SSP_S3 = 3'h3,
		SSP_S4 = 3'h4,
		SSP_S5 = 3'h5
	} ssp_sleep_t;
	localparam int SSP_STATE_W = 3;
	// Processor idle state that allows light load
	localparam logic [3:0] SSP_CPU_C10 = 4'ha;
	localparam int SSP_CSTATE_W = 4;
	// Reset levels of the pins (all deasserted, indication high)
	localparam logic SSP_PIN_RESET = 1'h1;
	// Index of each bit in the decoded output vector
	localparam int SSP_BIT_LAN = 0;
	localparam int SSP_BIT_WLAN = 1;
	localparam int SSP_BIT_IDLE = 2;
	localparam int SSP_BIT_S3 = 3;
	localparam int SSP_BIT_S4 = 4;
	localparam int SSP_BIT_S5 = 5;
	localparam int SSP_BIT_DS = 6;
	localparam int SSP_NOUT = 7;
	// Deep-sleep phase of the indication pin
	typedef enum logic [1:0] {
		SSP_DS_AWAKE = 2'h1,
		SSP_DS_ASLEEP = 2'h2
	} ssp_ds_t;
endpackage

// ===== rtl/ssp_sleep_controls.sv
// Sleep-state power control pin stage
//
// Contract
// (RQ1) The LAN power gate stays deasserted in S0 and whenever the always-on-domain sleep is deasserted.
// (RQ2) The LAN power gate asserts only when the LAN connect device may lose power.
// (RQ3) The wireless power gate asserts to allow removal of wireless LAN power.
// (RQ4) The wireless power gate is always deasserted in S0.
// (RQ5) Software should set the always-on sleep minimum width to its least value when the wireless gate is unused.
// (RQ6) The idle light-load output asserts when the device is idle and the processor is in C10.
// (RQ7) The S3 plane control asserts in every deep sleep state, S3, S4 and S5.
// (RQ8) The S4 plane control asserts in S4 and S5.
// (RQ9) The S5 plane control asserts only in S5.
// (RQ10) The deep-sleep indication is low while in deep sleep.
// (RQ11) The deep-sleep indication goes high on leaving deep sleep.
// (RQ12) The board uses the deep-sleep indication to switch the primary 1.8 V rail and never leaves it open.
// (RQ13) Every output is a registered decode that changes only when its inputs change.
`timescale 1ns/1ns
`default_nettype none
module ssp_sleep_controls (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] sleep_state,
	input wire logic always_on_domain_sleep_n,
	input wire logic lan_may_power_off,
	input wire logic wireless_may_power_off,
	input wire logic device_idle,
	input wire logic [3:0] cpu_cstate,
	input wire logic deep_sleep_state,
	output logic lan_power_gate_n,
	output logic wireless_power_gate_n,
	output logic idle_light_load_n,
	output logic standby_plane_off_n,
	output logic hibernate_plane_off_n,
	output logic softoff_plane_off_n,
	output logic deep_sleep_indication_n
);
	localparam int IN_W = ssp_pkg::SSP_STATE_W + ssp_pkg::SSP_CSTATE_W + 5;

	logic [IN_W-1:0] raw_in;
	logic [IN_W-1:0] sync_in;
	logic [2:0] st;
	logic aon_n;
	logic lan_ok;
	logic wl_ok;
	logic idle;
	logic [3:0] cst;
	logic ds;
	logic [ssp_pkg::SSP_NOUT-1:0] next_pins;
	ssp_pkg::ssp_ds_t ds_phase;
	ssp_pkg::ssp_ds_t next_ds_phase;

	// Inputs come from the state sequencer in another power well
	assign raw_in = {sleep_state, always_on_domain_sleep_n, lan_may_power_off, wireless_may_power_off,
		device_idle, cpu_cstate, deep_sleep_state};

	ssp_sync #(
		.WIDTH(IN_W)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d(raw_in),
		.q(sync_in)
	);

	assign st = sync_in[IN_W-1 -: 3];
	assign aon_n = sync_in[IN_W-4];
	assign lan_ok = sync_in[IN_W-5];
	assign wl_ok = sync_in[IN_W-6];
	assign idle = sync_in[IN_W-7];
	assign cst = sync_in[IN_W-8 -: 4];
	assign ds = sync_in[0];

	function automatic logic in_state(input logic [2:0] s, input ssp_pkg::ssp_sleep_t want);
		in_state = (s == want);
	endfunction

	// Deep-sleep phase tracking
	always_comb begin
		next_ds_phase = ds_phase;
		case (ds_phase)
			ssp_pkg::SSP_DS_AWAKE: begin
				if (ds) begin
					next_ds_phase = ssp_pkg::SSP_DS_ASLEEP; // RQ10
				end
			end
			ssp_pkg::SSP_DS_ASLEEP: begin
				if (!ds) begin
					next_ds_phase = ssp_pkg::SSP_DS_AWAKE; // RQ11
				end
			end
			default: begin
				next_ds_phase = ssp_pkg::SSP_DS_AWAKE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ds_phase <= ssp_pkg::SSP_DS_AWAKE;
		end else begin
			ds_phase <= next_ds_phase;
		end
	end

	// Active-low pin decode; a 0 bit asserts the pin
	always_comb begin
		next_pins = '1;
		// Gate off only outside S0 with always-on sleep asserted
		next_pins[ssp_pkg::SSP_BIT_LAN] = !(lan_ok && aon_n == 1'h0
			&& !in_state(st, ssp_pkg::SSP_S0)); // RQ1 RQ2
		next_pins[ssp_pkg::SSP_BIT_WLAN] = !(wl_ok && !in_state(st, ssp_pkg::SSP_S0)); // RQ3 RQ4
		next_pins[ssp_pkg::SSP_BIT_IDLE] = !(idle && cst == ssp_pkg::SSP_CPU_C10); // RQ6
		next_pins[ssp_pkg::SSP_BIT_S3] = !(in_state(st, ssp_pkg::SSP_S3) || in_state(st, ssp_pkg::SSP_S4)
			|| in_state(st, ssp_pkg::SSP_S5)); // RQ7
		next_pins[ssp_pkg::SSP_BIT_S4] = !(in_state(st, ssp_pkg::SSP_S4)
			|| in_state(st, ssp_pkg::SSP_S5)); // RQ8
		next_pins[ssp_pkg::SSP_BIT_S5] = !in_state(st, ssp_pkg::SSP_S5); // RQ9
		next_pins[ssp_pkg::SSP_BIT_DS] = (next_ds_phase != ssp_pkg::SSP_DS_ASLEEP); // RQ10 RQ11
	end

	// Registered pins, glitch free, one register each
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lan_power_gate_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			lan_power_gate_n <= next_pins[ssp_pkg::SSP_BIT_LAN]; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wireless_power_gate_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			wireless_power_gate_n <= next_pins[ssp_pkg::SSP_BIT_WLAN]; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_light_load_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			idle_light_load_n <= next_pins[ssp_pkg::SSP_BIT_IDLE]; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			standby_plane_off_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			standby_plane_off_n <= next_pins[ssp_pkg::SSP_BIT_S3]; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hibernate_plane_off_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			hibernate_plane_off_n <= next_pins[ssp_pkg::SSP_BIT_S4]; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			softoff_plane_off_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			softoff_plane_off_n <= next_pins[ssp_pkg::SSP_BIT_S5]; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			deep_sleep_indication_n <= ssp_pkg::SSP_PIN_RESET;
		end else begin
			deep_sleep_indication_n <= next_pins[ssp_pkg::SSP_BIT_DS]; // RQ13
		end
	end

	// Checks
	sequence s0_seen;
		in_state(st, ssp_pkg::SSP_S0);
	endsequence

	sequence lan_blocked;
		in_state(st, ssp_pkg::SSP_S0) || aon_n;
	endsequence

	sequence lan_released;
		lan_ok && !aon_n && !in_state(st, ssp_pkg::SSP_S0);
	endsequence

	sequence deep_planes;
		in_state(st, ssp_pkg::SSP_S3) || in_state(st, ssp_pkg::SSP_S4) || in_state(st, ssp_pkg::SSP_S5);
	endsequence

	sequence soft_off_seen;
		in_state(st, ssp_pkg::SSP_S5);
	endsequence

	sequence ds_entered;
		!ds ##1 ds;
	endsequence

	sequence ds_left;
		ds ##1 !ds;
	endsequence

	// Raw pin held across both synchroniser stages and the output register
	sequence pin_soft_off;
		(in_state(sleep_state, ssp_pkg::SSP_S5)) [*4];
	endsequence

	sequence pin_working;
		(in_state(sleep_state, ssp_pkg::SSP_S0)) [*4];
	endsequence

	sequence pin_deep_sleep;
		deep_sleep_state [*4];
	endsequence

	sequence pin_awake;
		!deep_sleep_state [*4];
	endsequence

	sequence pin_light_load;
		(device_idle && cpu_cstate == ssp_pkg::SSP_CPU_C10) [*4];
	endsequence

	lan_in_s0_a: assert property (@(posedge clk) disable iff (!rstn) lan_blocked |=> lan_power_gate_n) // RQ1
		else $error("LAN gate asserted in S0 or with always-on awake");
	lan_only_ok_a: assert property (@(posedge clk) disable iff (!rstn) !lan_ok |=> lan_power_gate_n) // RQ2
		else $error("LAN gate asserted without permission");
	wlan_assert_a: assert property (@(posedge clk) disable iff (!rstn) // RQ3
		(wl_ok && !in_state(st, ssp_pkg::SSP_S0)) |=> !wireless_power_gate_n)
		else $error("Wireless gate not asserted");
	wlan_s0_a: assert property (@(posedge clk) disable iff (!rstn) s0_seen |=> wireless_power_gate_n) // RQ4
		else $error("Wireless gate asserted in S0");
	idle_load_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6
		1'h1 |=> (idle_light_load_n == !($past(idle) && $past(cst) == ssp_pkg::SSP_CPU_C10)))
		else $error("Idle light-load output wrong");
	s3_plane_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7
		1'h1 |=> (standby_plane_off_n == !(in_state($past(st), ssp_pkg::SSP_S3)
		|| in_state($past(st), ssp_pkg::SSP_S4) || in_state($past(st), ssp_pkg::SSP_S5))))
		else $error("S3 plane control wrong");
	s4_plane_a: assert property (@(posedge clk) disable iff (!rstn) // RQ8
		(in_state(st, ssp_pkg::SSP_S4) || in_state(st, ssp_pkg::SSP_S5)) |=> !hibernate_plane_off_n)
		else $error("S4 plane control not asserted");
	s5_plane_a: assert property (@(posedge clk) disable iff (!rstn) // RQ9
		!in_state(st, ssp_pkg::SSP_S5) |=> softoff_plane_off_n)
		else $error("S5 plane control asserted outside S5");
	ds_low_a: assert property (@(posedge clk) disable iff (!rstn) ds |=> !deep_sleep_indication_n) // RQ10
		else $error("Deep-sleep indication high in deep sleep");
	ds_exit_a: assert property (@(posedge clk) disable iff (!rstn) // RQ11
		($fell(ds) ##1 1'h1) |-> deep_sleep_indication_n)
		else $error("Deep-sleep indication low after exit");
	stable_pins_a: assert property (@(posedge clk) disable iff (!rstn) // RQ13
		$stable(sync_in) ##1 $stable(sync_in) |=> $stable({lan_power_gate_n, wireless_power_gate_n,
		idle_light_load_n, standby_plane_off_n, hibernate_plane_off_n, softoff_plane_off_n,
		deep_sleep_indication_n}))
		else $error("Pin changed with stable inputs");

	// Full release conditions and exact entry and exit edges
	lan_assert_a: assert property (@(posedge clk) disable iff (!rstn) // RQ2
		lan_released |=> !lan_power_gate_n)
		else $error("LAN gate not asserted");

	wlan_release_a: assert property (@(posedge clk) disable iff (!rstn) // RQ3
		!wl_ok |=> wireless_power_gate_n)
		else $error("Wireless gate asserted without permission");

	s3_assert_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7
		deep_planes |=> !standby_plane_off_n)
		else $error("S3 plane control not asserted");

	s4_release_a: assert property (@(posedge clk) disable iff (!rstn) // RQ8
		!(in_state(st, ssp_pkg::SSP_S4) || in_state(st, ssp_pkg::SSP_S5)) |=> hibernate_plane_off_n)
		else $error("S4 plane control asserted outside S4 and S5");

	s5_assert_a: assert property (@(posedge clk) disable iff (!rstn) // RQ9
		soft_off_seen |=> !softoff_plane_off_n)
		else $error("S5 plane control not asserted");

	ds_high_a: assert property (@(posedge clk) disable iff (!rstn) // RQ11
		!ds |=> deep_sleep_indication_n)
		else $error("Deep-sleep indication low while awake");

	ds_enter_a: assert property (@(posedge clk) disable iff (!rstn) // RQ10
		ds_entered |=> $fell(deep_sleep_indication_n))
		else $error("Deep-sleep indication missed entry");

	ds_leave_a: assert property (@(posedge clk) disable iff (!rstn) // RQ11
		ds_left |=> $rose(deep_sleep_indication_n))
		else $error("Deep-sleep indication missed exit");

	s0_path_a: assert property (@(posedge clk) disable iff (!rstn) // RQ1 RQ4
		pin_working |-> lan_power_gate_n && wireless_power_gate_n)
		else $error("Power gate asserted in S0");

	softoff_path_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7 RQ8 RQ9
		pin_soft_off |-> !softoff_plane_off_n && !hibernate_plane_off_n && !standby_plane_off_n)
		else $error("Plane controls late in S5");

	ds_path_low_a: assert property (@(posedge clk) disable iff (!rstn) // RQ10
		pin_deep_sleep |-> !deep_sleep_indication_n)
		else $error("Deep-sleep indication late on entry");

	ds_path_high_a: assert property (@(posedge clk) disable iff (!rstn) // RQ11
		pin_awake |-> deep_sleep_indication_n)
		else $error("Deep-sleep indication late on exit");

	idle_path_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6
		pin_light_load |-> !idle_light_load_n)
		else $error("Idle light-load output late");

	sync_delay_a: assert property (@(posedge clk) disable iff (!rstn) // RQ13
		$past(rstn, 2) |-> sync_in == $past(raw_in, 2))
		else $error("Synchroniser latency wrong");
endmodule
`default_nettype wire

// ===== rtl/ssp_sync.sv
// Two-flip-flop synchroniser for level inputs
`timescale 1ns/1ns
`default_nettype none
module ssp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== tb/ssp_board_model.sv
// Board-side model: rail switches fed from the sleep-control pins
`timescale 1ns/1ns
`default_nettype none
module ssp_board_model (
	input wire logic deep_sleep_indication_n,
	input wire logic standby_plane_off_n,
	output logic primary_rail_1v8,
	output logic standby_rail_on
);
	// Indication always wired, rail follows it
	assign primary_rail_1v8 = deep_sleep_indication_n;
	assign standby_rail_on = standby_plane_off_n;
endmodule
`default_nettype wire

// ===== tb/test_sleep_state_power_controls.sv
// Random and corner-case bench for the sleep-control pin stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("BAD t=%0t %h %h", $time, a, b); end end
module test_sleep_state_power_controls;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [2:0] st = 3'h0;
	logic aon_n = 1'h1;
	logic lan_may = 1'h0;
	logic wl_may = 1'h0;
	logic idle = 1'h0;
	logic ds = 1'h0;
	logic [3:0] cst = 4'h0;
	wire [6:0] q;
	wire rail;
	wire standby_rail;
	logic [6:0] e;
	logic [31:0] seed = 32'h01e7;
	logic [2:0] states [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	ssp_sleep_controls DUT (.clk(clk), .rstn(rstn), .sleep_state(st), .always_on_domain_sleep_n(aon_n),
		.lan_may_power_off(lan_may), .wireless_may_power_off(wl_may), .device_idle(idle), .cpu_cstate(cst),
		.deep_sleep_state(ds), .lan_power_gate_n(q[0]), .wireless_power_gate_n(q[1]), .idle_light_load_n(q[2]),
		.standby_plane_off_n(q[3]), .hibernate_plane_off_n(q[4]), .softoff_plane_off_n(q[5]),
		.deep_sleep_indication_n(q[6]));
	ssp_board_model board (.deep_sleep_indication_n(q[6]), .standby_plane_off_n(q[3]),
		.primary_rail_1v8(rail), .standby_rail_on(standby_rail));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [6:0] expect_pins();
		logic [6:0] r;
		r[ssp_pkg::SSP_BIT_LAN] = !(lan_may && !aon_n && st != 3'h0);
		r[ssp_pkg::SSP_BIT_WLAN] = !(wl_may && st != 3'h0);
		r[ssp_pkg::SSP_BIT_IDLE] = !(idle && cst == ssp_pkg::SSP_CPU_C10);
		r[ssp_pkg::SSP_BIT_S3] = !(st == 3'h3 || st == 3'h4 || st == 3'h5);
		r[ssp_pkg::SSP_BIT_S4] = !(st == 3'h4 || st == 3'h5);
		r[ssp_pkg::SSP_BIT_S5] = !(st == 3'h5);
		r[ssp_pkg::SSP_BIT_DS] = !ds;
		return r;
	endfunction
	// Drive one input set, let the three-edge latency pass, compare every pin
	task automatic apply(input logic [2:0] s, input logic [4:0] f, input logic [3:0] c);
		@(posedge clk);
		#1;
		// Always-on sleep toggles freely, its minimum width taken as the least
		{st, aon_n, lan_may, wl_may, idle, ds, cst} = {s, f, c};
		repeat (4) @(posedge clk);
		#1;
		e = expect_pins();
		`CHK(q[ssp_pkg::SSP_BIT_LAN], e[ssp_pkg::SSP_BIT_LAN])
		`CHK(q[ssp_pkg::SSP_BIT_WLAN], e[ssp_pkg::SSP_BIT_WLAN])
		`CHK(q[ssp_pkg::SSP_BIT_IDLE], e[ssp_pkg::SSP_BIT_IDLE])
		`CHK(q[ssp_pkg::SSP_BIT_S3], e[ssp_pkg::SSP_BIT_S3])
		`CHK(q[ssp_pkg::SSP_BIT_S4], e[ssp_pkg::SSP_BIT_S4])
		`CHK(q[ssp_pkg::SSP_BIT_S5], e[ssp_pkg::SSP_BIT_S5])
		`CHK(q[ssp_pkg::SSP_BIT_DS], e[ssp_pkg::SSP_BIT_DS])
		`CHK(rail, e[ssp_pkg::SSP_BIT_DS])
		`CHK(standby_rail, e[ssp_pkg::SSP_BIT_S3])
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		logic [31:0] r;
		repeat (2) @(posedge clk);
		#1;
		`CHK(q, 7'h7f)
		@(posedge clk);
		#1;
		rstn = 1'h1;
		// Each state with permissions on, then off and a near-miss idle state
		for (int k = 0; k < 8; k++) begin
			if (k < 4) apply(states[k], 5'b01110, ssp_pkg::SSP_CPU_C10);
			else apply(states[k - 4], 5'b10011, 4'h9);
		end
		$display("corner test done");
		for (int k = 0; k < 300; k++) begin
			r = xs();
			// Now and then a raw state code, unlisted ones included
			apply(r[15:14] == 2'h0 ? r[18:16] : states[r[1:0]], r[6:2], r[8] ? ssp_pkg::SSP_CPU_C10 : r[12:9]);
		end
		$display("random test done");
		finish_test();
	end
endmodule
`default_nettype wire
